// ==== rtl/csr_cfg.svh ====
/*
  Constants for the clock select and reset control block: register offsets,
  fuse codes, start-up counts and delays.
  Assumes a 100 MHz system clock and a watchdog oscillator tick input.
*/
`ifndef CSR_CFG_SVH
`define CSR_CFG_SVH

// ******************************************
// Register map (byte addresses, word aligned)
// ******************************************
`define CSR_TRIM_IDX        6'h31
`define CSR_ADDR_TRIM       8'hc4
`define CSR_ADDR_STATUS     8'h00
`define CSR_ADDR_CTRL       8'h04

// ******************************************
// Fuse codes
// ******************************************
`define CSR_SEL_EXT         4'h0
`define CSR_SEL_RC1         4'h1
`define CSR_SEL_RC8         4'h4
`define CSR_SEL_PLL         4'h1
`define CSR_SUT_NONE        2'h0
`define CSR_SUT_SHORT       2'h1
`define CSR_SUT_LONG        2'h2
`define CSR_SUT_RSVD        2'h3

// ******************************************
// Timing
// ******************************************
`define CSR_CLK_MHZ         100
`define CSR_PIN_NS          50
`define CSR_PIN_CYC         8'((`CSR_PIN_NS * `CSR_CLK_MHZ) / 1000 + 1)
`define CSR_CK_EXT          17'd6
`define CSR_CK_PLL_1K       17'd1024
`define CSR_CK_PLL_16K      17'd16384
`define CSR_WDT_KHZ         128
`define CSR_DLY_SHORT_US    4100
`define CSR_DLY_LONG_US     65000
`define CSR_DLY_SHORT_TK    17'((`CSR_DLY_SHORT_US * `CSR_WDT_KHZ) / 1000)
`define CSR_DLY_LONG_TK     17'((`CSR_DLY_LONG_US * `CSR_WDT_KHZ) / 1000)
`define CSR_TRIM_RST        8'h00

`endif

// ==== rtl/csr_pkg.sv ====
/*
  Types for the clock select and reset control block.
  Assumes csr_cfg.svh supplies all numeric constants.
*/
package csr_pkg;

  typedef enum logic [1:0] {
    CSR_SRC_RC  = 2'b00,
    CSR_SRC_EXT = 2'b01,
    CSR_SRC_PLL = 2'b10,
    CSR_SRC_OFF = 2'b11
  } csr_src_e;

  typedef enum logic [1:0] {
    CSR_ST_HOLD = 2'b00,
    CSR_ST_RTD  = 2'b01,
    CSR_ST_CKC  = 2'b10,
    CSR_ST_RUN  = 2'b11
  } csr_state_e;

  typedef struct packed {
    logic [3:0] clk_sel;
    logic       pll_fuse_n;
    logic [1:0] startup_time_fuses;
    logic       rst_pin_dis_n;
  } csr_fuse_s;

  typedef struct packed {
    logic por;
    logic ext_pin_n;
    logic wdt_expire;
    logic bod;
  } csr_rst_src_s;

  typedef struct packed {
    csr_fuse_s    fuse;
    csr_state_e   state;
    logic [16:0]  cnt;
    logic [7:0]   pin_cnt;
    logic [7:0]   trim;
    csr_src_e     src;
    logic [2:0]   rc_div;
    logic         rst_out;
    logic         wake_busy;
    logic         wdt_pulse;
    logic         wait_n;
    logic [7:0]   rdata;
    logic [3:0]   cause;
  } csr_state_s;

endpackage

// ==== rtl/csr_ctrl.sv ====
/*
  Clock source selection and reset sequencing with the oscillator trim
  register, reached over Avalon-MM.
  Assumes all inputs but arst_n synchronous to clk_sys, reset detectors and fuses
  given as levels, and wdt_osc_tick a one-cycle pulse per watchdog
  oscillator period.
*/
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "csr_cfg.svh"

// Function
// - Reset loads 1 MHz calibration byte into trim; arst_n loads 00 instead
// - Trim raises frequency monotonically, zero lowest
// - Trim 00/7F/FF span 50-200 percent nominal
// - Fuses 0000 with PLL off pick external
// - External: 6 CK, delay none/4.1/65 ms
// - PLL 64 MHz clock feeds timer, system
// - PLL fuse with 0001 gives PLL/4
// - PLL: 1K or 16K CK plus delay
// - Reset is OR of four sources
// - Pin resets if enabled, low over 50ns
// - Watchdog expiry with enable causes reset
// - Reset initialises registers, execution from zero
// - Power-down wake uses only clock count
// - Real-time delay timed by watchdog oscillator
// - Codes 0001-0100 pick RC 1-8 MHz
// - Watchdog pulse one cycle, delay after fall
module csr_ctrl (
  input  wire logic                  clk_sys,
  input  wire logic                  arst_n,
  input  wire csr_pkg::csr_fuse_s    fuses,
  input  wire csr_pkg::csr_rst_src_s rst_src,
  input  wire logic                  wdt_enable,
  input  wire logic [7:0]            cal_byte,
  input  wire logic                  wdt_osc_tick,
  input  wire logic                  sys_ck_tick,
  input  wire logic                  wake_req,
  input  wire logic [7:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  output logic                       core_rst,
  output logic [7:0]                 rc_trim,
  output csr_pkg::csr_src_e          clk_src,
  output logic [2:0]                 rc_freq_sel,
  output logic                       wake_busy
);
  import csr_pkg::*;

  // Assertions below share one clock and the async reset
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  csr_state_s s_reg;
  csr_state_s s_next;
  logic       rst_any;
  logic       pin_low;
  logic [16:0] ck_need;
  logic [16:0] rt_need;
  logic       acc;

  // ******************************************
  // Reset sources and start-up tables
  // ******************************************
  // Pin counts only when the shared pin is configured as reset
  assign pin_low = s_reg.fuse.rst_pin_dis_n & ~rst_src.ext_pin_n;
  // Watchdog expiry only counts when the watchdog is enabled
  assign rst_any = rst_src.por | rst_src.bod
                 | (s_reg.pin_cnt >= `CSR_PIN_CYC)
                 | s_reg.wdt_pulse;
  assign acc     = (avs_read | avs_write) & s_reg.wait_n;

  // Clock-count and real-time parts from latched fuses
  always_comb begin
    ck_need = `CSR_CK_EXT;
    rt_need = 17'h00000;
    if (s_reg.src == CSR_SRC_PLL) begin
      ck_need = (s_reg.fuse.startup_time_fuses == `CSR_SUT_RSVD) ? `CSR_CK_PLL_16K
                                                  : `CSR_CK_PLL_1K;
    end
    unique case (s_reg.fuse.startup_time_fuses)
      `CSR_SUT_NONE:  rt_need = 17'h00000;
      `CSR_SUT_SHORT: rt_need = `CSR_DLY_SHORT_TK;
      `CSR_SUT_LONG:  rt_need = `CSR_DLY_LONG_TK;
      // Reserved code: PLL defines it as no delay, others take the longest
      `CSR_SUT_RSVD:  rt_need = (s_reg.src == CSR_SRC_PLL) ? 17'h00000
                                                           : `CSR_DLY_LONG_TK;
    endcase
  end

  // ******************************************
  // Next-state logic
  // ******************************************
  // One process builds the whole next state
  always_comb begin
    s_next = s_reg;
    s_next.wait_n = 1'b0;
    s_next.wdt_pulse = rst_src.wdt_expire & wdt_enable & ~s_reg.wdt_pulse;
    s_next.pin_cnt = pin_low ? ((s_reg.pin_cnt == 8'hff) ? s_reg.pin_cnt
                                                         : s_reg.pin_cnt + 8'h01)
                             : 8'h00;
    if (rst_any) begin
      // Hold: latch fuses, reload trim, restart sequence
      s_next.fuse    = fuses;
      s_next.trim    = cal_byte;
      s_next.state   = CSR_ST_HOLD;
      s_next.cnt     = 17'h00000;
      s_next.rst_out = 1'b1;
      s_next.wake_busy = 1'b0;
      s_next.cause   = rst_src;
    end else begin
      unique case (s_reg.state)
        CSR_ST_HOLD: begin
          s_next.state = CSR_ST_RTD;
          s_next.cnt   = 17'h00000;
        end
        // Real-time part counts watchdog oscillator ticks
        CSR_ST_RTD: begin
          if (s_reg.cnt >= rt_need) begin
            s_next.state = CSR_ST_CKC;
            s_next.cnt   = 17'h00000;
          end else if (wdt_osc_tick) begin
            s_next.cnt = s_reg.cnt + 17'h00001;
          end
        end
        // Clock-count part counts selected system clock edges
        CSR_ST_CKC: begin
          if (s_reg.cnt >= ck_need) begin
            s_next.state     = CSR_ST_RUN;
            s_next.rst_out   = 1'b0;
            s_next.wake_busy = 1'b0;
          end else if (sys_ck_tick) begin
            s_next.cnt = s_reg.cnt + 17'h00001;
          end
        end
        CSR_ST_RUN: begin
          // Wake-up skips the real-time part entirely
          if (wake_req) begin
            s_next.state     = CSR_ST_CKC;
            s_next.cnt       = 17'h00000;
            s_next.wake_busy = 1'b1;
          end
        end
      endcase
      // Register bus; one wait cycle so readdata comes from a flop
      if (acc) begin
        s_next.wait_n = 1'b0;
      end else if (avs_read | avs_write) begin
        s_next.wait_n = 1'b1;
      end
      if ((avs_read | avs_write) & ~s_reg.wait_n & ~acc) begin
        s_next.rdata = 8'h00;
        unique case (avs_address)
          `CSR_ADDR_TRIM:   s_next.rdata = s_reg.trim;
          `CSR_ADDR_STATUS: s_next.rdata = {2'b00, s_reg.state, s_reg.cause};
          `CSR_ADDR_CTRL:   s_next.rdata = {6'h00, s_reg.src};
          default:          s_next.rdata = 8'h00;
        endcase
      end
      // Write lands on the answer edge, when the master sees waitrequest low
      if (avs_write & acc & avs_byteenable[0]
          & (avs_address == `CSR_ADDR_TRIM)) begin
        s_next.trim = avs_writedata[7:0];
      end
    end
    // Source decode from latched fuses
    if (!s_reg.fuse.pll_fuse_n && s_reg.fuse.clk_sel == `CSR_SEL_PLL) begin
      s_next.src = CSR_SRC_PLL;
    end else if (s_reg.fuse.pll_fuse_n && s_reg.fuse.clk_sel == `CSR_SEL_EXT) begin
      s_next.src = CSR_SRC_EXT;
    end else if (s_reg.fuse.pll_fuse_n && s_reg.fuse.clk_sel >= `CSR_SEL_RC1
                 && s_reg.fuse.clk_sel <= `CSR_SEL_RC8) begin
      s_next.src = CSR_SRC_RC;
    end else begin
      s_next.src = CSR_SRC_OFF;
    end
    s_next.rc_div = 3'(s_reg.fuse.clk_sel - `CSR_SEL_RC1);
  end

  // ******************************************
  // State register
  // ******************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_reg         <= '0;
      s_reg.trim    <= `CSR_TRIM_RST;
      s_reg.rst_out <= 1'b1;
      s_reg.src     <= CSR_SRC_OFF;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from state flops
  assign avs_readdata    = {24'h000000, s_reg.rdata};
  assign avs_waitrequest = ~s_reg.wait_n;
  assign core_rst        = s_reg.rst_out;
  assign rc_trim         = s_reg.trim;
  assign clk_src         = s_reg.src;
  assign rc_freq_sel     = s_reg.rc_div;
  assign wake_busy       = s_reg.wake_busy;

  // ******************************************
  // Assertions
  // ******************************************
  sequence s_wdt_fire;
    rst_src.wdt_expire & wdt_enable & ~s_reg.wdt_pulse;
  endsequence
  sequence s_pulse_one;
    s_reg.wdt_pulse ##1 !s_reg.wdt_pulse;
  endsequence

  a_wdt_pulse_len: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_wdt_fire |=> s_pulse_one) else $error("watchdog pulse not one cycle");
  a_any_src_rst: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (rst_src.por | rst_src.bod) |=> core_rst) else $error("reset source ignored");
  a_trim_reload: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rst_src.por |=> (rc_trim == $past(cal_byte))) else $error("trim not reloaded");
  a_fuse_hold: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !rst_any |=> (s_reg.fuse == $past(s_reg.fuse))) else $error("fuses changed");
  a_pin_off: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !s_reg.fuse.rst_pin_dis_n |=> (s_reg.pin_cnt == 8'h00)) else $error("pin counted");
  a_wake_no_rt: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (s_reg.state == CSR_ST_RUN && wake_req && !rst_any) |=> s_reg.state == CSR_ST_CKC)
    else $error("wake went through delay");
  a_pll_src: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (!s_reg.fuse.pll_fuse_n && s_reg.fuse.clk_sel == `CSR_SEL_PLL) |=> clk_src == CSR_SRC_PLL)
    else $error("pll not chosen");
  a_ext_src: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (s_reg.fuse.pll_fuse_n && s_reg.fuse.clk_sel == `CSR_SEL_EXT) |=> clk_src == CSR_SRC_EXT)
    else $error("external not chosen");
  a_rsvd_long: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (s_reg.fuse.startup_time_fuses == `CSR_SUT_RSVD && s_reg.src != CSR_SRC_PLL) |-> rt_need == `CSR_DLY_LONG_TK)
    else $error("reserved code short");
  a_ck_done: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (s_reg.state == CSR_ST_CKC && s_reg.cnt >= ck_need && !rst_any) |=> !core_rst)
    else $error("reset not released");
  a_rt_tick: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (s_reg.state == CSR_ST_RTD && !wdt_osc_tick && s_reg.cnt < rt_need && !rst_any)
    |=> $stable(s_reg.cnt)) else $error("delay counted without tick");

  // ******************************************
  // Register bus checks
  // ******************************************
  // A request seen with waitrequest high is answered on the next edge
  a_wait_answer: assert property (
    ((avs_read || avs_write) && avs_waitrequest && !rst_any) |=> !avs_waitrequest)
    else $error("bus request not answered");

  // The answer stands for one cycle only
  a_wait_one: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");

  // A write to the trim register lands on the answer edge
  a_trim_write: assert property (
    (avs_write && !avs_waitrequest && avs_byteenable[0] && !rst_any
     && avs_address == `CSR_ADDR_TRIM) |=> rc_trim == $past(avs_writedata[7:0]))
    else $error("trim write lost");

  // No bus answer while any reset source is active
  a_bus_quiet: assert property (
    rst_any |=> avs_waitrequest)
    else $error("bus answered in reset");

  // ******************************************
  // Reset sequencing checks
  // ******************************************
  // Every reset cycle reloads the calibration byte
  a_rst_trim: assert property (
    rst_any |=> rc_trim == $past(cal_byte))
    else $error("trim not loaded in reset");

  // Any reset restarts the sequence and holds the core
  a_rst_state: assert property (
    rst_any |=> (s_reg.state == CSR_ST_HOLD && core_rst))
    else $error("reset did not restart");

  // Fuses follow their pins only while reset is active
  a_fuse_latch: assert property (
    rst_any |=> s_reg.fuse == $past(fuses))
    else $error("fuses not latched");

  // A filtered pin low resets the device
  a_pin_filter: assert property (
    (s_reg.pin_cnt >= `CSR_PIN_CYC) |=> core_rst)
    else $error("pin reset missed");

  // A short glitch never accumulates across gaps
  a_pin_clear: assert property (
    !pin_low |=> s_reg.pin_cnt == 8'h00)
    else $error("pin filter kept count");

  // A disabled watchdog never makes a pulse
  a_wdt_gated: assert property (
    !wdt_enable |=> !s_reg.wdt_pulse)
    else $error("watchdog pulse while disabled");

  // The watchdog pulse resets the device
  a_wdt_rst: assert property (
    s_reg.wdt_pulse |=> core_rst)
    else $error("watchdog pulse ignored");

  // Delay starts once the reset source has gone
  a_hold_to_rtd: assert property (
    (s_reg.state == CSR_ST_HOLD && !rst_any) |=> s_reg.state == CSR_ST_RTD)
    else $error("delay did not start");

  // Real-time part hands over to the clock count with a fresh counter
  a_rt_done: assert property (
    (s_reg.state == CSR_ST_RTD && s_reg.cnt >= rt_need && !rst_any)
    |=> (s_reg.state == CSR_ST_CKC && s_reg.cnt == 17'h00000))
    else $error("real-time part not ended");

  // Clock count moves only on system clock ticks
  a_ck_tick: assert property (
    (s_reg.state == CSR_ST_CKC && !sys_ck_tick && s_reg.cnt < ck_need && !rst_any)
    |=> $stable(s_reg.cnt))
    else $error("clock counted without tick");

  // PLL code 11 takes the long clock count
  a_pll_long: assert property (
    (s_reg.src == CSR_SRC_PLL && s_reg.fuse.startup_time_fuses == `CSR_SUT_RSVD)
    |-> ck_need == `CSR_CK_PLL_16K)
    else $error("pll long count wrong");

  // PLL code 11 has no real-time part
  a_pll_rsvd_rt: assert property (
    (s_reg.src == CSR_SRC_PLL && s_reg.fuse.startup_time_fuses == `CSR_SUT_RSVD) |-> rt_need == 17'h00000)
    else $error("pll code 11 delayed");

  // External clock always counts six cycles
  a_ext_six: assert property (
    s_reg.src == CSR_SRC_EXT |-> ck_need == `CSR_CK_EXT)
    else $error("external count wrong");

  // RC codes select the internal oscillator
  a_rc_src: assert property (
    (s_reg.fuse.pll_fuse_n && s_reg.fuse.clk_sel >= `CSR_SEL_RC1
     && s_reg.fuse.clk_sel <= `CSR_SEL_RC8) |=> clk_src == CSR_SRC_RC)
    else $error("rc not chosen");

  // Running means the core is out of reset
  a_run_free: assert property (
    s_reg.state == CSR_ST_RUN |-> !core_rst)
    else $error("reset held while running");

  // Wake-up never puts the core back into reset
  a_wake_quiet: assert property (
    wake_busy |-> !core_rst)
    else $error("wake asserted reset");
endmodule

// ==== verification/csr_env_model.sv ====
/*
  Far-side model: power, brown-out and watchdog detectors, the reset pin
  and the watchdog and system clock tick sources.
  Assumes the bench requests each reset source as an active-high level.
*/
`timescale 1ns/1ps
module csr_env_model (
  input  wire logic                   clk_sys,
  input  wire logic [3:0]             src_req,
  output csr_pkg::csr_rst_src_s       rst_src,
  output logic                        wdt_osc_tick,
  output logic                        sys_ck_tick
);
  import csr_pkg::*;
  logic [1:0] wdt_div = 2'h0;
  logic [1:0] ck_div  = 2'h0;

  // Request order por, pin, watchdog, brown-out; the pin is active low
  assign rst_src = csr_rst_src_s'({src_req[3], ~src_req[2], src_req[1:0]});

  // Ticks at fixed rates, so the clock never jumps between cycles
  always_ff @(posedge clk_sys) begin
    wdt_div <= (wdt_div == 2'h1) ? 2'h0 : wdt_div + 2'h1;
    ck_div  <= (ck_div == 2'h2) ? 2'h0 : ck_div + 2'h1;
  end
  assign wdt_osc_tick = (wdt_div == 2'h0);
  assign sys_ck_tick  = (ck_div == 2'h0);
endmodule

// ==== verification/clock_select_reset_control_bench.sv ====
/*
  Self-checking bench for csr_ctrl: register access, clock source decode,
  reset sources and start-up delays.
  Assumes csr_env_model on the far side and a 100 MHz clock.
*/
`timescale 1ns/1ps
`include "csr_cfg.svh"
module clock_select_reset_control_bench;
  import csr_pkg::*;
  logic        clk_sys, arst_n, wdt_enable, wake_req, wdt_osc_tick, sys_ck_tick;
  logic        avs_read, avs_write, avs_waitrequest, core_rst, wake_busy;
  logic [3:0]  src_req, avs_byteenable;
  logic [7:0]  cal_byte, avs_address, rc_trim;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [2:0]  rc_freq_sel;
  csr_fuse_s    fuses;
  csr_rst_src_s rst_src;
  csr_src_e     clk_src;
  int          err_count, n_tests, t;

  // ******************************************
  // Clock, design and far side
  // ******************************************
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  csr_ctrl dut (.clk_sys(clk_sys), .arst_n(arst_n), .fuses(fuses), .rst_src(rst_src),
    .wdt_enable(wdt_enable), .cal_byte(cal_byte), .wdt_osc_tick(wdt_osc_tick),
    .sys_ck_tick(sys_ck_tick), .wake_req(wake_req), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .core_rst(core_rst), .rc_trim(rc_trim),
    .clk_src(clk_src), .rc_freq_sel(rc_freq_sel), .wake_busy(wake_busy));

  csr_env_model env (.clk_sys(clk_sys), .src_req(src_req), .rst_src(rst_src),
    .wdt_osc_tick(wdt_osc_tick), .sys_ck_tick(sys_ck_tick));

  // ******************************************
  // Shared tasks
  // ******************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One bus cycle, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
  endtask

  // Power-on reset with new fuses; counts watchdog ticks until release
  task automatic boot(input logic [7:0] f);
    int n;
    n = 0;
    t = 0;
    src_req <= 4'h8;
    fuses <= csr_fuse_s'(f);
    repeat (4) @(posedge clk_sys);
    src_req <= 4'h0;
    do begin
      @(posedge clk_sys);
      n++;
      t += int'(wdt_osc_tick === 1'b1);
    end while (core_rst !== 1'b0 && n < 40000);
    chk("reset release", 32'h0, {31'h0, core_rst});
  endtask

  // Holds a reset source for len cycles and checks whether reset followed
  task automatic src_hit(input logic [3:0] req, input int len, input logic exp);
    logic hit;
    int   n;
    hit = 1'b0;
    src_req <= req;
    repeat (len) @(posedge clk_sys);
    src_req <= 4'h0;
    repeat (12) begin
      @(posedge clk_sys);
      hit |= (core_rst === 1'b1);
    end
    chk("reset taken", {31'h0, exp}, {31'h0, hit});
    for (n = 0; n < 40000 && core_rst !== 1'b0; n++) @(posedge clk_sys);
  endtask

  // ******************************************
  // Scenarios
  // ******************************************
  // Power-on with external clock; all three registers readable
  task automatic sc_boot_ext();
    boot(8'h09);
    chk("source ext", CSR_SRC_EXT, clk_src);
    bus(1'b0, `CSR_ADDR_CTRL, 32'h0);
    chk("ctrl ext", 32'h1, q);
    bus(1'b0, `CSR_ADDR_STATUS, 32'h0);
    chk("status", 32'h3c, q);
    bus(1'b0, `CSR_ADDR_TRIM, 32'h0);
    chk("trim loaded", 32'h96, q);
    chk("rc_trim loaded", 32'h96, {24'h0, rc_trim});
  endtask

  // Software trims across the whole range, lowest to highest
  task automatic sc_trim_rw();
    logic [7:0] v;
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h7f : 8'hff;
      bus(1'b1, `CSR_ADDR_TRIM, {24'h0, v});
      bus(1'b0, `CSR_ADDR_TRIM, 32'h0);
      chk("trim rw", {24'h0, v}, q);
      chk("rc_trim", {24'h0, v}, {24'h0, rc_trim});
    end
    bus(1'b1, 8'h80, 32'h5a);
    bus(1'b0, 8'h80, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask

  // Watchdog, brown-out and pin resets in turn, with the pin filter and watchdog gate
  task automatic sc_sources();
    wdt_enable <= 1'b1;
    src_hit(4'h2, 1, 1'b1);
    wdt_enable <= 1'b0;
    src_hit(4'h2, 1, 1'b0);
    src_hit(4'h1, 3, 1'b1);
    bus(1'b1, `CSR_ADDR_TRIM, 32'h5a);
    src_hit(4'h4, 10, 1'b1);
    bus(1'b0, `CSR_ADDR_TRIM, 32'h0);
    chk("trim reload", 32'h96, q);
    src_hit(4'h4, 2, 1'b0);
  endtask

  // Fuses move while running; the source must not follow
  task automatic sc_fuse_hold();
    fuses <= csr_fuse_s'(8'h29);
    repeat (5) @(posedge clk_sys);
    chk("source held", CSR_SRC_EXT, clk_src);
    boot(8'h08);
    src_hit(4'h4, 10, 1'b0);
  endtask

  // RC and PLL source decodes, the invalid code included
  task automatic sc_decode();
    boot(8'h29);
    chk("source rc", CSR_SRC_RC, clk_src);
    chk("rc 2 MHz", 32'h1, {29'h0, rc_freq_sel});
    bus(1'b0, `CSR_ADDR_CTRL, 32'h0);
    chk("ctrl rc", 32'h0, q);
    boot(8'h59);
    chk("source off", CSR_SRC_OFF, clk_src);
    boot(8'h11);
    chk("source pll", CSR_SRC_PLL, clk_src);
  endtask

  // Real-time delays counted in watchdog ticks
  task automatic sc_delays();
    boot(8'h0b);
    chk("short delay", 32'h1,
        {31'h0, t >= `CSR_DLY_SHORT_TK && t < `CSR_DLY_LONG_TK});
    boot(8'h0f);
    chk("reserved delay", 32'h1, {31'h0, t >= `CSR_DLY_LONG_TK});
  endtask

  // Wake counts clock ticks only, far short of the real-time delay
  task automatic sc_wake();
    int n;
    @(posedge clk_sys);
    wake_req <= 1'b1;
    @(posedge clk_sys);
    wake_req <= 1'b0;
    t = 0;
    for (n = 0; n < 4 && wake_busy !== 1'b1; n++) @(posedge clk_sys);
    chk("wake busy", 32'h1, {31'h0, wake_busy});
    for (n = 0; n < 60 && wake_busy !== 1'b0; n++) begin
      @(posedge clk_sys);
      t += int'(sys_ck_tick === 1'b1);
    end
    chk("wake done", 32'h1, {31'h0, wake_busy === 1'b0 && t >= 6});
  endtask

  // Async reset in mid-run, then a power-on to reload the trim
  task automatic sc_async();
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("async core_rst", 32'h1, {31'h0, core_rst});
    chk("async trim", 32'h0, {24'h0, rc_trim});
    chk("async wait", 32'h1, {31'h0, avs_waitrequest});
    arst_n <= 1'b1;
    boot(8'h09);
    chk("trim after async", 32'h96, {24'h0, rc_trim});
  endtask

  initial begin
    arst_n = 1'b0;
    fuses = csr_fuse_s'(8'h09);
    src_req = 4'h8;
    {wdt_enable, wake_req, avs_read, avs_write} = 4'h0;
    cal_byte = 8'h96;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    sc_boot_ext();
    sc_trim_rw();
    sc_sources();
    sc_fuse_hold();
    sc_decode();
    sc_delays();
    sc_wake();
    sc_async();
    finish_test();
  end

  // Whole run is near 21k cycles; allow about 40k
  initial begin
    #400000;
    err_count++;
    finish_test();
  end
endmodule
